// [hw/eahb_map.vh]
`ifndef EAHB_MAP_VH
`define EAHB_MAP_VH

// Transfer type encodings
`define EAHB_TR_IDLE 2'h0
`define EAHB_TR_BUSY 2'h1
`define EAHB_TR_NONSEQ 2'h2
`define EAHB_TR_SEQ 2'h3

// Slave response encodings
`define EAHB_RESP_OKAY 2'h0
`define EAHB_RESP_ERROR 2'h1

// Burst length field (burst code bits 2:1)
`define EAHB_BLEN_SINGLE 2'h0
`define EAHB_BLEN_4 2'h1
`define EAHB_BLEN_8 2'h2
`define EAHB_BLEN_16 2'h3

// Beat counts
`define EAHB_BEATS_1 5'h01
`define EAHB_BEATS_4 5'h04
`define EAHB_BEATS_8 5'h08
`define EAHB_BEATS_16 5'h10

// Meaningful address width on the pins
`define EAHB_ADDR_BITS 20

// Strap lines on port two data bus and capture delay after reset
`define EAHB_STRAP_BITS 29
`define EAHB_STRAP_WAIT 2'h3

// Synchronised pin bundle layout per port
`define EAHB_SY_W 37
`define EAHB_SY_HCLK 36
`define EAHB_SY_GRANT 35
`define EAHB_SY_READY 34
`define EAHB_SY_RESP 32

`endif

// [hw/eahb_sync.v]
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for pins from a foreign clock
module eahb_sync #(
  parameter W = 1
) (
  // Clock and control
  input wire clk_sys,
  input wire rst_b,
  input wire ce,
  // Data
  input wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] meta_r; // First stage, read only by second
  reg [W-1:0] sync_r; // Second stage, safe to use

  // Both stages freeze with the clock enable
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end
    else if (ce)
    begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;

endmodule

`default_nettype wire

// [hw/eahb_master_ports.v]
// Operation
// - Request bus while port has work
// - Hold lock through whole locked burst
// - Own bus only on grant with ready
// - Drive 32-bit address, low 20 meaningful
// - Write direction high write, low read
// - Encode nonseq, seq, idle, busy transfers
// - Signal byte, halfword or word size
// - Support 4/8/16 incrementing or wrapping bursts
// - Drive four-bit protection with each access
// - Transfer ends only on ready high
// - Tell OKAY from ERROR response
// - Each port runs off its own bus clock
// - Port two low 29 data lines are straps
// - Port two has response and 32-bit data
`timescale 1ns/1ps
`default_nettype none
`include "eahb_map.vh"

module eahb_master_ports #(
  parameter ADDR_BITS = `EAHB_ADDR_BITS,
  parameter STRAP_BITS = `EAHB_STRAP_BITS
) (
  // System
  input wire clk_sys,
  input wire rst_b,
  input wire ce,
  // Port one command side
  input wire port_one_cmd_valid,
  output wire port_one_cmd_ready,
  input wire port_one_cmd_write,
  input wire [31:0] port_one_cmd_addr,
  input wire [1:0] port_one_cmd_size,
  input wire [2:0] port_one_cmd_burst,
  input wire [3:0] port_one_cmd_prot,
  input wire port_one_cmd_lock,
  input wire port_one_wd_valid,
  input wire [31:0] port_one_wd_data,
  output wire port_one_wd_take,
  output wire port_one_rd_valid,
  output wire [31:0] port_one_rd_data,
  output wire port_one_done,
  output wire port_one_err,
  // Port one pins
  input wire port_one_hclk,
  output wire port_one_hbusreq,
  output wire port_one_hlock,
  input wire port_one_hgrant,
  input wire port_one_hready,
  input wire [1:0] port_one_hresp,
  output wire [31:0] port_one_haddr,
  output wire port_one_hwrite,
  output wire [1:0] port_one_htrans,
  output wire [1:0] port_one_hsize,
  output wire [2:0] port_one_hburst,
  output wire [3:0] port_one_hprot,
  output wire port_one_hctl_oe,
  output wire [31:0] port_one_hwdata_o,
  input wire [31:0] port_one_hwdata_i,
  output wire port_one_hwdata_oe,
  // Port two command side
  input wire port_two_cmd_valid,
  output wire port_two_cmd_ready,
  input wire port_two_cmd_write,
  input wire [31:0] port_two_cmd_addr,
  input wire [1:0] port_two_cmd_size,
  input wire [2:0] port_two_cmd_burst,
  input wire [3:0] port_two_cmd_prot,
  input wire port_two_cmd_lock,
  input wire port_two_wd_valid,
  input wire [31:0] port_two_wd_data,
  output wire port_two_wd_take,
  output wire port_two_rd_valid,
  output wire [31:0] port_two_rd_data,
  output wire port_two_done,
  output wire port_two_err,
  // Port two pins
  input wire port_two_hclk,
  output wire port_two_hbusreq,
  output wire port_two_hlock,
  input wire port_two_hgrant,
  input wire port_two_hready,
  input wire [1:0] port_two_hresp,
  output wire [31:0] port_two_haddr,
  output wire port_two_hwrite,
  output wire [1:0] port_two_htrans,
  output wire [1:0] port_two_hsize,
  output wire [2:0] port_two_hburst,
  output wire [3:0] port_two_hprot,
  output wire port_two_hctl_oe,
  output wire [31:0] port_two_hwdata_o,
  input wire [31:0] port_two_hwdata_i,
  output wire port_two_hwdata_oe,
  // Configuration straps
  output wire [STRAP_BITS-1:0] config_strap_inputs,
  output wire config_strap_valid
);

  localparam ST_IDLE = 1'b0; // No work
  localparam ST_XFER = 1'b1; // Requesting or moving beats

  // Inputs packed per port, port one in the low slice
  wire [1:0] cmd_valid_a = {port_two_cmd_valid, port_one_cmd_valid};
  wire [1:0] cmd_write_a = {port_two_cmd_write, port_one_cmd_write};
  wire [63:0] cmd_addr_a = {port_two_cmd_addr, port_one_cmd_addr};
  wire [3:0] cmd_size_a = {port_two_cmd_size, port_one_cmd_size};
  wire [5:0] cmd_burst_a = {port_two_cmd_burst, port_one_cmd_burst};
  wire [7:0] cmd_prot_a = {port_two_cmd_prot, port_one_cmd_prot};
  wire [1:0] cmd_lock_a = {port_two_cmd_lock, port_one_cmd_lock};
  wire [1:0] wd_valid_a = {port_two_wd_valid, port_one_wd_valid};
  wire [63:0] wd_data_a = {port_two_wd_data, port_one_wd_data};
  wire [1:0] hclk_a = {port_two_hclk, port_one_hclk};
  wire [1:0] hgrant_a = {port_two_hgrant, port_one_hgrant};
  wire [1:0] hready_a = {port_two_hready, port_one_hready};
  wire [3:0] hresp_a = {port_two_hresp, port_one_hresp};
  wire [63:0] hrdata_a = {port_two_hwdata_i, port_one_hwdata_i};

  // Outputs packed per port
  wire [1:0] cmd_ready_a;
  wire [1:0] wd_take_a;
  wire [1:0] rd_valid_a;
  wire [63:0] rd_data_a;
  wire [1:0] done_a;
  wire [1:0] err_a;
  wire [1:0] hbusreq_a;
  wire [1:0] hlock_a;
  wire [63:0] haddr_a;
  wire [1:0] hwrite_a;
  wire [3:0] htrans_a;
  wire [3:0] hsize_a;
  wire [5:0] hburst_a;
  wire [7:0] hprot_a;
  wire [1:0] hctl_oe_a;
  wire [63:0] hwdata_a;
  wire [1:0] hwdata_oe_a;

  // Synchronised pin bundles of both ports
  wire [2*`EAHB_SY_W-1:0] sy_a;

  // Strap capture state
  reg [STRAP_BITS-1:0] strap_r; // Captured configuration
  reg strap_done_r; // Straps taken, port two may drive data
  reg [1:0] strap_cnt_r; // Waits for synchroniser to fill

  // Port one never carries straps
  wire [1:0] data_ok_a = {strap_done_r, 1'b1};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : port
      // Per-port control and data registers
      reg st_r; // Idle or busy
      reg own_r; // Address and control bus is ours
      reg seqok_r; // A beat already went out in this tenure
      reg [31:0] addr_r; // Address of beat on offer
      reg [4:0] left_r; // Beats still to issue
      reg [1:0] trans_r; // Transfer type driven
      reg write_r; // Direction of burst
      reg [1:0] size_r; // Beat size
      reg [2:0] burst_r; // Burst code
      reg [3:0] prot_r; // Protection code
      reg lock_r; // Locked burst
      reg have_r; // Write data for beat on offer is held
      reg [31:0] pre_r; // Write data for beat on offer
      reg [31:0] hwdata_r; // Write data in data phase
      reg dph_act_r; // A data phase is running
      reg dph_write_r; // Running data phase is a write
      reg [31:0] rdata_r; // Last read beat
      reg rdv_r; // Read beat pulse
      reg done_r; // Burst end pulse
      reg err_r; // Error seen in last burst
      reg take_r; // Write data taken pulse
      reg [`EAHB_SY_W-1:0] smp_r; // Pin bundle one cycle back

      // Bus clock and bus inputs reach logic only through two flops
      eahb_sync #(.W(`EAHB_SY_W)) u_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .ce(ce),
        .d({hclk_a[g], hgrant_a[g], hready_a[g], hresp_a[g*2 +: 2], hrdata_a[g*32 +: 32]}),
        .q(sy_a[g*`EAHB_SY_W +: `EAHB_SY_W])
      );

      wire [`EAHB_SY_W-1:0] sy = sy_a[g*`EAHB_SY_W +: `EAHB_SY_W];
      wire hclk_s = sy[`EAHB_SY_HCLK];
      // Slave pins change just after the edge, so use the sample from before it
      wire grant_s = smp_r[`EAHB_SY_GRANT];
      wire ready_s = smp_r[`EAHB_SY_READY];
      wire [1:0] resp_s = smp_r[`EAHB_SY_RESP +: 2];
      wire [31:0] rd_s = smp_r[31:0];

      // Rising bus clock edge seen in the fabric domain
      wire edge_w = hclk_s & ~smp_r[`EAHB_SY_HCLK];

      // Burst length and wrap boundary
      wire [4:0] beats_w = (burst_r[2:1] == `EAHB_BLEN_SINGLE) ? `EAHB_BEATS_1 : `EAHB_BEATS_4 << (burst_r[2:1] - 2'h1);
      wire [4:0] cmd_beats_w = (cmd_burst_a[g*3+1 +: 2] == `EAHB_BLEN_SINGLE) ? `EAHB_BEATS_1 :
                               `EAHB_BEATS_4 << (cmd_burst_a[g*3+1 +: 2] - 2'h1);
      wire wrap_w = ~burst_r[0] & (burst_r[2:1] != `EAHB_BLEN_SINGLE);
      wire [31:0] step_w = 32'h1 << size_r;
      wire [31:0] mask_w = ({27'h0, beats_w} << size_r) - 32'h1;
      wire [31:0] inc_w = addr_r + step_w;
      wire [31:0] next_addr_w = wrap_w ? ((addr_r & ~mask_w) | (inc_w & mask_w)) : inc_w;

      // Beat accepted on a ready edge while we own the bus
      wire acc_w = own_r & ((trans_r == `EAHB_TR_NONSEQ) | (trans_r == `EAHB_TR_SEQ));
      wire [4:0] left_n = acc_w ? left_r - 5'h1 : left_r;
      wire have_n = have_r & ~acc_w;
      // Ownership starts only when grant and ready are both high
      wire seq_n = grant_s & own_r & (acc_w | seqok_r);
      wire present_w = grant_s & (left_n != 5'h0) & (st_r == ST_XFER);
      wire can_w = ~write_r | have_n | wd_valid_a[g];
      wire take_w = write_r & ~have_n & wd_valid_a[g];

      // Writes need their first beat of data before the command is taken
      wire cmd_ok_w = (st_r == ST_IDLE) & (~cmd_write_a[g] | wd_valid_a[g]);
      wire cmd_go_w = ce & cmd_valid_a[g] & cmd_ok_w;

      // Main sequencer, advanced on bus clock edges
      always @(posedge clk_sys)
      begin
        if (!rst_b)
        begin
          st_r <= ST_IDLE;
          own_r <= 1'b0;
          seqok_r <= 1'b0;
          addr_r <= 32'h0;
          left_r <= 5'h0;
          trans_r <= `EAHB_TR_IDLE;
          write_r <= 1'b0;
          size_r <= 2'h0;
          burst_r <= 3'h0;
          prot_r <= 4'h0;
          lock_r <= 1'b0;
          have_r <= 1'b0;
          pre_r <= 32'h0;
          hwdata_r <= 32'h0;
          dph_act_r <= 1'b0;
          dph_write_r <= 1'b0;
          rdata_r <= 32'h0;
          rdv_r <= 1'b0;
          done_r <= 1'b0;
          err_r <= 1'b0;
          take_r <= 1'b0;
          smp_r <= {`EAHB_SY_W{1'b0}};
        end
        else if (ce)
        begin
          // Pulses last one fabric cycle
          rdv_r <= 1'b0;
          done_r <= 1'b0;
          take_r <= 1'b0;
          smp_r <= sy;
          if (edge_w && ready_s)
          begin
            // Ownership follows grant at every ready edge
            own_r <= grant_s;
            seqok_r <= seq_n;
            // Close the running data phase
            if (dph_act_r)
            begin
              if (!dph_write_r)
              begin
                rdata_r <= rd_s;
                rdv_r <= 1'b1;
              end
              if (resp_s == `EAHB_RESP_ERROR)
                err_r <= 1'b1;
            end
            dph_act_r <= acc_w;
            dph_write_r <= write_r;
            if (acc_w)
            begin
              addr_r <= next_addr_w;
              hwdata_r <= pre_r;
              left_r <= left_n;
            end
            have_r <= have_n;
            // Choose what to offer next
            if (present_w && can_w)
            begin
              trans_r <= seq_n ? `EAHB_TR_SEQ : `EAHB_TR_NONSEQ;
              if (take_w)
              begin
                pre_r <= wd_data_a[g*32 +: 32];
                have_r <= 1'b1;
                take_r <= 1'b1;
              end
            end
            else if (present_w)
              trans_r <= seq_n ? `EAHB_TR_BUSY : `EAHB_TR_IDLE; // Waiting on write data
            else
              trans_r <= `EAHB_TR_IDLE;
            // Burst ends when its last data phase closes
            if ((st_r == ST_XFER) && dph_act_r && !acc_w && (left_n == 5'h0))
            begin
              st_r <= ST_IDLE;
              done_r <= 1'b1;
            end
          end
          else if (edge_w && dph_act_r && (resp_s == `EAHB_RESP_ERROR))
          begin
            // First error cycle: cancel the rest of the burst
            trans_r <= `EAHB_TR_IDLE;
            left_r <= 5'h0;
          end
          // New command, wins over edge updates of the same fields
          if (cmd_go_w)
          begin
            st_r <= ST_XFER;
            addr_r <= cmd_addr_a[g*32 +: 32];
            left_r <= cmd_beats_w;
            write_r <= cmd_write_a[g];
            size_r <= cmd_size_a[g*2 +: 2];
            burst_r <= cmd_burst_a[g*3 +: 3];
            prot_r <= cmd_prot_a[g*4 +: 4];
            lock_r <= cmd_lock_a[g];
            err_r <= 1'b0;
            have_r <= cmd_write_a[g];
            pre_r <= wd_data_a[g*32 +: 32];
            take_r <= cmd_write_a[g];
          end
        end
      end

      // Command side
      assign cmd_ready_a[g] = ce & cmd_ok_w;
      assign wd_take_a[g] = take_r;
      assign rd_valid_a[g] = rdv_r;
      assign rd_data_a[g*32 +: 32] = rdata_r;
      assign done_a[g] = done_r;
      assign err_a[g] = err_r;
      // Pin side
      assign hbusreq_a[g] = (st_r == ST_XFER);
      assign hlock_a[g] = lock_r & (st_r == ST_XFER);
      assign haddr_a[g*32 +: 32] = {{(32-ADDR_BITS){1'b0}}, addr_r[ADDR_BITS-1:0]};
      assign hwrite_a[g] = write_r;
      assign htrans_a[g*2 +: 2] = trans_r;
      assign hsize_a[g*2 +: 2] = size_r;
      assign hburst_a[g*3 +: 3] = burst_r;
      assign hprot_a[g*4 +: 4] = prot_r;
      assign hctl_oe_a[g] = own_r;
      assign hwdata_a[g*32 +: 32] = hwdata_r;
      assign hwdata_oe_a[g] = dph_act_r & dph_write_r & data_ok_a[g];
    end
  endgenerate

  // Straps sampled once the synchroniser has filled after reset
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      strap_r <= {STRAP_BITS{1'b0}};
      strap_done_r <= 1'b0;
      strap_cnt_r <= 2'h0;
    end
    else if (ce && !strap_done_r)
    begin
      if (strap_cnt_r == `EAHB_STRAP_WAIT)
      begin
        strap_r <= sy_a[`EAHB_SY_W +: STRAP_BITS];
        strap_done_r <= 1'b1;
      end
      else
        strap_cnt_r <= strap_cnt_r + 2'h1;
    end
  end

  assign config_strap_inputs = strap_r;
  assign config_strap_valid = strap_done_r;

  // Unpack outputs
  assign port_one_cmd_ready = cmd_ready_a[0];
  assign port_one_wd_take = wd_take_a[0];
  assign port_one_rd_valid = rd_valid_a[0];
  assign port_one_rd_data = rd_data_a[31:0];
  assign port_one_done = done_a[0];
  assign port_one_err = err_a[0];
  assign port_one_hbusreq = hbusreq_a[0];
  assign port_one_hlock = hlock_a[0];
  assign port_one_haddr = haddr_a[31:0];
  assign port_one_hwrite = hwrite_a[0];
  assign port_one_htrans = htrans_a[1:0];
  assign port_one_hsize = hsize_a[1:0];
  assign port_one_hburst = hburst_a[2:0];
  assign port_one_hprot = hprot_a[3:0];
  assign port_one_hctl_oe = hctl_oe_a[0];
  assign port_one_hwdata_o = hwdata_a[31:0];
  assign port_one_hwdata_oe = hwdata_oe_a[0];
  assign port_two_cmd_ready = cmd_ready_a[1];
  assign port_two_wd_take = wd_take_a[1];
  assign port_two_rd_valid = rd_valid_a[1];
  assign port_two_rd_data = rd_data_a[63:32];
  assign port_two_done = done_a[1];
  assign port_two_err = err_a[1];
  assign port_two_hbusreq = hbusreq_a[1];
  assign port_two_hlock = hlock_a[1];
  assign port_two_haddr = haddr_a[63:32];
  assign port_two_hwrite = hwrite_a[1];
  assign port_two_htrans = htrans_a[3:2];
  assign port_two_hsize = hsize_a[3:2];
  assign port_two_hburst = hburst_a[5:3];
  assign port_two_hprot = hprot_a[7:4];
  assign port_two_hctl_oe = hctl_oe_a[1];
  assign port_two_hwdata_o = hwdata_a[63:32];
  assign port_two_hwdata_oe = hwdata_oe_a[1];

endmodule

`default_nettype wire

// [sim/eahb_master_ports_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the external master ports
module eahb_master_ports_sva #(
  parameter ADDR_BITS = 20
) (
  // System
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  // Port one command side
  input wire logic port_one_cmd_valid,
  input wire logic port_one_cmd_ready,
  input wire logic port_one_cmd_write,
  input wire logic port_one_wd_valid,
  input wire logic port_one_wd_take,
  input wire logic port_one_done,
  input wire logic port_one_err,
  // Port one pins
  input wire logic port_one_hclk,
  input wire logic port_one_hbusreq,
  input wire logic port_one_hlock,
  input wire logic [31:0] port_one_haddr,
  input wire logic [1:0] port_one_htrans,
  // Port two pins and straps
  input wire logic [31:0] port_two_haddr,
  input wire logic port_two_hwdata_oe,
  input wire logic config_strap_valid
);
  // Previous bus clock level, raw
  logic hclk_d = 1'b0;
  // Cycles since bus clock rise, saturating
  logic [3:0] since = 4'hf;

  // Track bus clock rises seen at the fabric clock
  always @(posedge clk_sys)
  begin
    hclk_d <= port_one_hclk;
    if (port_one_hclk && !hclk_d)
      since <= 4'h0;
    else if (since != 4'hf)
      since <= since + 4'h1;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_addr_top_zero: assert property ((port_one_haddr >> ADDR_BITS) == 0 && (port_two_haddr >> ADDR_BITS) == 0)
    else $error("high address bits set");
  a_req_after_cmd: assert property (ce && port_one_cmd_valid && port_one_cmd_ready |=> port_one_hbusreq)
    else $error("no request after command");
  a_req_drop_done: assert property ($fell(port_one_hbusreq) |-> port_one_done)
    else $error("request dropped early");
  a_ready_cond: assert property (port_one_cmd_ready |-> ce && (!port_one_cmd_write || port_one_wd_valid))
    else $error("bad command ready");
  a_take_one_cycle: assert property (port_one_wd_take |=> !port_one_wd_take)
    else $error("long take pulse");
  a_done_one_cycle: assert property (port_one_done |=> !port_one_done)
    else $error("done longer than one cycle");
  a_lock_in_req: assert property (port_one_hlock |-> port_one_hbusreq)
    else $error("lock without bus request");
  a_trans_on_edge: assert property ($changed(port_one_htrans) |-> since >= 4'h1 && since <= 4'h5)
    else $error("transfer type off edge");
  a_err_with_done: assert property ($rose(port_one_err) |-> port_one_done)
    else $error("error flag rose without done");
  a_strap_first: assert property (port_two_hwdata_oe |-> config_strap_valid)
    else $error("data driven before straps");
endmodule

bind eahb_master_ports eahb_master_ports_sva #(.ADDR_BITS(ADDR_BITS)) i_eahb_master_ports_sva (.*);
`default_nettype wire

// [sim/eahb_slave_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Off-chip arbiter and slave for one port
module eahb_slave_model #(
  parameter HALF = 40
) (
  // Pins
  output logic hclk = 1'b0,
  output logic hgrant = 1'b0,
  output logic hready = 1'b1,
  output logic [1:0] hresp = 2'h0,
  input wire logic hbusreq,
  input wire logic hlock,
  input wire logic [31:0] haddr,
  input wire logic hwrite,
  input wire logic [1:0] htrans,
  input wire logic [1:0] hsize,
  input wire logic [2:0] hburst,
  input wire logic [3:0] hprot,
  input wire logic hctl_oe,
  input wire logic [31:0] hwdata_o,
  input wire logic hwdata_oe,
  output logic [31:0] hwdata_i,
  // Bench controls
  input wire logic grant_req,
  input wire logic [1:0] waits,
  input wire logic err_arm,
  input wire logic strap_on,
  input wire logic [31:0] strap,
  // Observations
  output logic [31:0] wsum = 32'h0,
  output logic [7:0] nbeat = 8'h0,
  output logic [9:0] ctl = 10'h0
);
  logic dph = 1'b0; // Data phase open
  logic dw = 1'b0; // Open phase is a write
  logic [31:0] da = 32'h0; // Open phase address
  logic [31:0] idle = 32'h0; // Pattern on a released line
  logic [1:0] wc = 2'h0; // Wait cycles left
  logic nw; // Address phase accepted now

  assign nw = hready & hctl_oe & htrans[1];
  // Released idle line inverts at every bus clock unless straps are shown, so a stale sample cannot pass
  assign hwdata_i = hwdata_oe ? hwdata_o : strap_on ? strap : (dph & !dw) ? ~{12'h000, da[19:0]} : idle;

  // Bus clock runs free from its own source
  always #(HALF) hclk = ~hclk;

  // Arbiter and slave on the bus clock
  always @(posedge hclk)
  begin
    idle <= ~hwdata_i;
    if (hready)
    begin
      hgrant <= grant_req | (hlock & hgrant);
      // Count only beats closed with OKAY
      if (dph && hresp == 2'h0)
      begin
        nbeat <= nbeat + 8'h1;
        wsum <= wsum + (dw ? hwdata_i ^ da : 32'h0);
      end
      dph <= nw;
      if (nw)
      begin
        dw <= hwrite;
        da <= haddr;
        ctl <= {hwrite, hsize, hburst, hprot};
      end
      hready <= !nw || (waits == 2'h0 && !err_arm);
      hresp <= (nw && err_arm) ? 2'h1 : 2'h0;
      wc <= err_arm ? 2'h1 : waits;
    end
    else if (wc > 2'h1)
      wc <= wc - 2'h1;
    else
      hready <= 1'b1;
  end
endmodule
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for both master ports
module testbench;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic so = 1'b1; // Straps shown on port two
  logic [1:0] cv = 2'h0, cw = 2'h0, ck = 2'h0, wv = 2'h0, gq = 2'h3, ea = 2'h0;
  logic [31:0] ca [2] = '{32'h0, 32'h0}, wd [2] = '{32'h0, 32'h0};
  logic [1:0] cs [2] = '{2'h0, 2'h0}, ws [2] = '{2'h0, 2'h0};
  logic [2:0] cb [2] = '{3'h0, 3'h0};
  logic [3:0] cp [2] = '{4'h0, 4'h0};
  wire [1:0] cr, wt, rv, dn, er, hc, br, lk, gt, ry, hw, oe, we;
  wire [1:0] rs [2], ht [2], hz [2];
  wire [2:0] hb [2];
  wire [3:0] hp [2];
  wire [31:0] rd [2], ad [2], wo [2], wi [2], sm [2];
  wire [7:0] nb [2];
  wire [9:0] ct [2];
  wire [28:0] sp;
  wire sv;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;

  eahb_master_ports i_eahb_master_ports (
    .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce),
    .port_one_cmd_valid(cv[0]), .port_one_cmd_ready(cr[0]), .port_one_cmd_write(cw[0]), .port_one_cmd_addr(ca[0]),
    .port_one_cmd_size(cs[0]), .port_one_cmd_burst(cb[0]), .port_one_cmd_prot(cp[0]), .port_one_cmd_lock(ck[0]),
    .port_one_wd_valid(wv[0]), .port_one_wd_data(wd[0]), .port_one_wd_take(wt[0]), .port_one_rd_valid(rv[0]),
    .port_one_rd_data(rd[0]), .port_one_done(dn[0]), .port_one_err(er[0]), .port_one_hclk(hc[0]),
    .port_one_hbusreq(br[0]), .port_one_hlock(lk[0]), .port_one_hgrant(gt[0]), .port_one_hready(ry[0]),
    .port_one_hresp(rs[0]), .port_one_haddr(ad[0]), .port_one_hwrite(hw[0]), .port_one_htrans(ht[0]),
    .port_one_hsize(hz[0]), .port_one_hburst(hb[0]), .port_one_hprot(hp[0]), .port_one_hctl_oe(oe[0]),
    .port_one_hwdata_o(wo[0]), .port_one_hwdata_i(wi[0]), .port_one_hwdata_oe(we[0]),
    .port_two_cmd_valid(cv[1]), .port_two_cmd_ready(cr[1]), .port_two_cmd_write(cw[1]), .port_two_cmd_addr(ca[1]),
    .port_two_cmd_size(cs[1]), .port_two_cmd_burst(cb[1]), .port_two_cmd_prot(cp[1]), .port_two_cmd_lock(ck[1]),
    .port_two_wd_valid(wv[1]), .port_two_wd_data(wd[1]), .port_two_wd_take(wt[1]), .port_two_rd_valid(rv[1]),
    .port_two_rd_data(rd[1]), .port_two_done(dn[1]), .port_two_err(er[1]), .port_two_hclk(hc[1]),
    .port_two_hbusreq(br[1]), .port_two_hlock(lk[1]), .port_two_hgrant(gt[1]), .port_two_hready(ry[1]),
    .port_two_hresp(rs[1]), .port_two_haddr(ad[1]), .port_two_hwrite(hw[1]), .port_two_htrans(ht[1]),
    .port_two_hsize(hz[1]), .port_two_hburst(hb[1]), .port_two_hprot(hp[1]), .port_two_hctl_oe(oe[1]),
    .port_two_hwdata_o(wo[1]), .port_two_hwdata_i(wi[1]), .port_two_hwdata_oe(we[1]),
    .config_strap_inputs(sp), .config_strap_valid(sv));

  // One far-side model per port, each with its own bus clock rate
  for (genvar g = 0; g < 2; g++)
  begin : gm
    eahb_slave_model #(.HALF(40 - 5 * g)) i_eahb_slave_model (
      .hclk(hc[g]), .hgrant(gt[g]), .hready(ry[g]), .hresp(rs[g]), .hbusreq(br[g]), .hlock(lk[g]), .haddr(ad[g]),
      .hwrite(hw[g]), .htrans(ht[g]), .hsize(hz[g]), .hburst(hb[g]), .hprot(hp[g]), .hctl_oe(oe[g]),
      .hwdata_o(wo[g]), .hwdata_oe(we[g]), .hwdata_i(wi[g]), .grant_req(gq[g]), .waits(ws[g]), .err_arm(ea[g]),
      .strap_on(so && g == 1), .strap(32'h0ab5_1c3e), .wsum(sm[g]), .nbeat(nb[g]), .ctl(ct[g]));
  end

  // Fabric clock, 100 MHz
  always #5 clk_sys = ~clk_sys;

  // Watchdog against a hung handshake
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      print_verdict();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Pin address of beat i, top bits cleared
  function automatic logic [31:0] beat_addr(input logic [31:0] a, input logic [1:0] s, input logic [2:0] b,
                                            input int i);
    logic [31:0] m;
    m = (b[0] || b[2:1] == 2'h0) ? 32'hffff_ffff : ((32'h2 << b[2:1]) << s) - 32'h1;
    return ((a & ~m) | ((a + (i << s)) & m)) & 32'h000f_ffff;
  endfunction

  // One command on port p, followed to done and judged
  task automatic run(input int p, input logic w, input logic [31:0] a, input logic [1:0] s, input logic [2:0] b,
                     input logic k, input logic e);
    logic [31:0] s0, sum = 32'h0;
    logic [7:0] n0;
    int n, i = 0, r = 0;
    logic fin = 1'b0;
    n = (b[2:1] == 2'h0) ? 1 : 4 << (b[2:1] - 2'h1);
    s0 = sm[p];
    n0 = nb[p];
    @(posedge clk_sys);
    cv[p] <= 1'b1;
    cw[p] <= w;
    ca[p] <= a;
    cs[p] <= s;
    cb[p] <= b;
    cp[p] <= {b, w};
    ck[p] <= k;
    wv[p] <= w;
    wd[p] <= 32'h3c5a_0000;
    @(negedge clk_sys);
    while (cr[p] !== 1'b1)
      @(negedge clk_sys);
    @(posedge clk_sys);
    cv[p] <= 1'b0;
    while (!fin)
    begin
      @(negedge clk_sys);
      if (rv[p] === 1'b1)
      begin
        check("rdata", rd[p], ~beat_addr(a, s, b, r));
        r++;
      end
      i += (wt[p] === 1'b1);
      fin = (dn[p] === 1'b1);
      @(posedge clk_sys);
      wd[p] <= 32'h3c5a_0000 ^ i;
      wv[p] <= w && (i < n) && !fin;
    end
    for (i = 0; i < n && !e; i++)
      sum += (32'h3c5a_0000 ^ i) ^ beat_addr(a, s, b, i);
    check("err", er[p], e);
    check("beats", nb[p] - n0, e ? 0 : n);
    check("wsum", sm[p] - s0, w ? sum : 32'h0);
    check("ctl", ct[p], {w, s, b, b, w});
    if (!e)
      check("reads", r, w ? 0 : n);
  endtask

  task automatic t_reset;
    @(negedge clk_sys);
    check("idle", {br, oe, ht[0], ht[1]}, 8'h0);
    repeat (8) @(posedge clk_sys);
    check("straps", {sv, sp}, {1'b1, 29'h0ab5_1c3e});
    so <= 1'b0;
  endtask

  task automatic t_bursts;
    for (int b = 0; b < 8; b++)
      run(0, b[1] ^ b[0], 32'hfff5_3c3c, 2'(b % 3), 3'(b), 1'b0, 1'b0);
  endtask

  task automatic t_waits;
    ws[0] <= 2'h2;
    run(0, 1'b0, 32'h0000_1230, 2'h2, 3'h3, 1'b0, 1'b0);
    run(0, 1'b1, 32'h0000_1238, 2'h1, 3'h2, 1'b0, 1'b0);
    ws[0] <= 2'h0;
  endtask

  task automatic t_error;
    ea[0] <= 1'b1;
    run(0, 1'b1, 32'h0000_4440, 2'h2, 3'h3, 1'b0, 1'b1);
    ea[0] <= 1'b0;
    run(0, 1'b0, 32'h0000_4440, 2'h2, 3'h0, 1'b0, 1'b0);
  endtask

  task automatic t_grant;
    gq[0] <= 1'b0;
    repeat (40) @(posedge clk_sys);
    fork
      run(0, 1'b0, 32'h0000_0800, 2'h2, 3'h5, 1'b0, 1'b0);
      begin
        repeat (60) @(negedge clk_sys);
        check("no_grant", {oe[0], br[0]}, 2'h1);
        gq[0] <= 1'b1;
      end
    join
  endtask

  task automatic t_lock;
    fork
      run(0, 1'b0, 32'h0000_0c00, 2'h2, 3'h7, 1'b1, 1'b0);
      begin
        repeat (60) @(negedge clk_sys);
        check("lock", lk[0], 1'b1);
        gq[0] <= 1'b0;
      end
    join
    gq[0] <= 1'b1;
  endtask

  task automatic t_port_two;
    run(1, 1'b1, 32'h0002_0100, 2'h2, 3'h3, 1'b0, 1'b0);
    run(1, 1'b0, 32'h0002_0102, 2'h1, 3'h2, 1'b0, 1'b0);
  endtask

  // Clock enable low must hold both ports off
  task automatic t_ce;
    @(posedge clk_sys);
    ce <= 1'b0;
    repeat (4) @(negedge clk_sys);
    check("ce_ready", cr, 2'h0);
    @(posedge clk_sys);
    ce <= 1'b1;
  endtask

  task automatic print_verdict;
    if (err_total == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset();
    t_bursts();
    t_waits();
    t_error();
    t_grant();
    t_lock();
    t_port_two();
    t_ce();
    print_verdict();
  end
endmodule
`default_nettype wire
